// file: logic/csr_byte_reg.sv
`timescale 1ns/1ns
`default_nettype none
module csr_byte_reg
	import csr_pkg::*;
#(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input  wire logic       clock,    // core clock
	input  wire logic       rst,      // sync reset, active high
	input  wire logic       wr_en,    // write this byte
	input  wire logic [7:0] wr_data,  // value to store
	output logic      [7:0] value     // stored byte
);
	logic [7:0] value_r;
	logic [7:0] value_nxt;

	always_comb begin
		value_nxt = wr_en ? wr_data : value_r;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			value_r <= RESET_VAL;
		end else begin
			value_r <= value_nxt;
		end
	end

	assign value = value_r;
endmodule // csr_byte_reg
`default_nettype wire

// file: logic/csr_pkg.sv
// Function
// RQ1: with CRC enabled, load low seed byte at transmit, receive, calculate start.
// RQ2: with CRC enabled, load high seed byte at those same three starts.
// RQ3: in 8-bit CRC mode, ignore high seed byte, use low byte only.
// RQ4: seeds and reserved 25h read/write; seeds reset 63h, reserved 00h.
// RQ5: selector picks diagnostic pin source; 000 drives low, 001 drives high.
// RQ6: code 010 drives Miller envelope, 011 drives serial data before encoding.
// RQ7: code 100 drives carrier demodulator, 101 drives subcarrier demodulator.
// RQ8: software never writes codes 110/111; upper five bits stay zero.
// RQ9: software uses demodulator codes only for type A at 106 kBd.
// RQ10: location 27h is write-only; software never alters its value.
// RQ11: nearly-full flag set when free FIFO space is at or below threshold.
// RQ12: nearly-empty flag set when FIFO entries are at or below threshold.
// RQ13: width option set selects 8-bit CRC, clear selects 16-bit CRC.
// RQ14: a selector write changes the diagnostic pin from the next cycle.
package csr_pkg;
	localparam int          ADDR_W           = 6;
	localparam int          DATA_W           = 8;
	localparam int          CNT_W            = 7;
	localparam int          THR_W            = 6;
	localparam int          SEL_W            = 3;

	localparam logic [5:0]  ADDR_SEED_LOW    = 6'h23;
	localparam logic [5:0]  ADDR_SEED_HIGH   = 6'h24;
	localparam logic [5:0]  ADDR_RSVD_ZERO   = 6'h25;
	localparam logic [5:0]  ADDR_DIAG_SEL    = 6'h26;
	localparam logic [5:0]  ADDR_RSVD_UNDEF  = 6'h27;
	localparam logic [5:0]  ADDR_FIFO_THR    = 6'h29;

	localparam logic [7:0]  RST_SEED         = 8'h63;
	localparam logic [7:0]  RST_RSVD_ZERO    = 8'h00;
	localparam logic [7:0]  RST_DIAG_SEL     = 8'h00;
	localparam logic [7:0]  RST_RSVD_UNDEF   = 8'h00;
	localparam logic [7:0]  RST_FIFO_THR     = 8'h08;
	localparam logic [7:0]  READ_ZERO        = 8'h00;

	localparam logic [6:0]  FIFO_DEPTH       = 7'h40;
	localparam logic [15:0] SEED_ZERO        = 16'h0000;

	typedef enum logic [2:0] {
		SEL_LOW     = 3'b000,
		SEL_HIGH    = 3'b001,
		SEL_MILLER  = 3'b010,
		SEL_SERIAL  = 3'b011,
		SEL_CARRIER = 3'b100,
		SEL_SUBCAR  = 3'b101,
		SEL_RSVD6   = 3'b110,
		SEL_RSVD7   = 3'b111
	} csr_diag_sel_t;
endpackage

// file: logic/csr_regs.sv
`timescale 1ns/1ns
`default_nettype none
module csr_regs
	import csr_pkg::*;
(
	input  wire logic        clock,                 // core clock, 50 MHz
	input  wire logic        rst,                   // sync reset, active high
	input  wire logic [5:0]  reg_addr,              // register address
	input  wire logic [7:0]  reg_wdata,             // write data
	input  wire logic        reg_wr,                // write strobe
	input  wire logic        reg_rd,                // read strobe
	output logic      [7:0]  reg_rdata,             // read data
	output logic             reg_rvalid,            // read data valid pulse
	input  wire logic        crc_enable,            // CRC calculation on
	input  wire logic        crc_short_width_select,// 8-bit CRC when set
	input  wire logic        tx_start,              // transmission begins
	input  wire logic        rx_start,              // reception begins
	input  wire logic        crc_calculate_command, // calculate command starts
	output logic             crc_load,              // preset CRC register
	output logic      [15:0] crc_load_value,        // preset value
	input  wire logic        miller_envelope,       // encoder envelope
	input  wire logic        tx_serial_data,        // data before encoding
	input  wire logic        carrier_demod,         // carrier demod output
	input  wire logic        subcarrier_demod,      // subcarrier demod output
	output logic             diag_output_pin,       // diagnostic pin level
	input  wire logic [6:0]  fifo_count,            // entries held, 0..64
	output logic             fifo_nearly_full_flag, // free space low
	output logic             fifo_nearly_empty_flag // contents low
);
	logic [7:0]    seed_low;
	logic [7:0]    seed_high;
	logic [7:0]    rsvd_zero;
	logic [7:0]    diag_sel;
	logic [7:0]    rsvd_undef;
	logic [7:0]    fifo_thr;
	logic [5:0]    fill_threshold;
	logic          crc_start;
	csr_diag_sel_t sel_eff;
	logic [6:0]    fifo_free;

	logic [7:0]    rdata_r;
	logic [7:0]    rdata_nxt;
	logic          rvalid_r;
	logic          rvalid_nxt;
	logic          load_r;
	logic          load_nxt;
	logic [15:0]   load_val_r;
	logic [15:0]   load_val_nxt;
	logic          pin_r;
	logic          pin_nxt;
	logic          full_r;
	logic          full_nxt;
	logic          empty_r;
	logic          empty_nxt;

	// register storage
	csr_byte_reg #(.RESET_VAL(RST_SEED)) u_seed_low (
		.clock   (clock),
		.rst     (rst),
		.wr_en   (reg_wr && reg_addr == ADDR_SEED_LOW), // RQ4
		.wr_data (reg_wdata),
		.value   (seed_low)
	);
	csr_byte_reg #(.RESET_VAL(RST_SEED)) u_seed_high (
		.clock   (clock),
		.rst     (rst),
		.wr_en   (reg_wr && reg_addr == ADDR_SEED_HIGH), // RQ4
		.wr_data (reg_wdata),
		.value   (seed_high)
	);
	csr_byte_reg #(.RESET_VAL(RST_RSVD_ZERO)) u_rsvd_zero (
		.clock   (clock),
		.rst     (rst),
		.wr_en   (reg_wr && reg_addr == ADDR_RSVD_ZERO), // RQ4
		.wr_data (reg_wdata),
		.value   (rsvd_zero)
	);
	csr_byte_reg #(.RESET_VAL(RST_DIAG_SEL)) u_diag_sel (
		.clock   (clock),
		.rst     (rst),
		.wr_en   (reg_wr && reg_addr == ADDR_DIAG_SEL),
		.wr_data (reg_wdata),
		.value   (diag_sel)
	);
	// write-only: held so the value survives, never read back
	csr_byte_reg #(.RESET_VAL(RST_RSVD_UNDEF)) u_rsvd_undef (
		.clock   (clock),
		.rst     (rst),
		.wr_en   (reg_wr && reg_addr == ADDR_RSVD_UNDEF), // RQ10
		.wr_data (reg_wdata),
		.value   (rsvd_undef)
	);
	csr_byte_reg #(.RESET_VAL(RST_FIFO_THR)) u_fifo_thr (
		.clock   (clock),
		.rst     (rst),
		.wr_en   (reg_wr && reg_addr == ADDR_FIFO_THR),
		.wr_data (reg_wdata),
		.value   (fifo_thr)
	);

	assign fill_threshold = fifo_thr[THR_W-1:0];

	// register read port
	always_comb begin
		rdata_nxt  = rdata_r;
		rvalid_nxt = reg_rd;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_SEED_LOW:   rdata_nxt = seed_low;  // RQ4
				ADDR_SEED_HIGH:  rdata_nxt = seed_high; // RQ4
				ADDR_RSVD_ZERO:  rdata_nxt = rsvd_zero; // RQ4
				ADDR_DIAG_SEL:   rdata_nxt = diag_sel;
				ADDR_FIFO_THR:   rdata_nxt = fifo_thr;
				// unmapped and write-only locations read zero
				default:         rdata_nxt = READ_ZERO; // RQ10
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_r  <= READ_ZERO;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// CRC preset; any of the three start events triggers it
	assign crc_start = tx_start || rx_start || crc_calculate_command;

	always_comb begin
		load_nxt     = crc_start && crc_enable; // RQ1 RQ2
		load_val_nxt = load_val_r;
		if (crc_start && crc_enable) begin
			if (crc_short_width_select) begin
				load_val_nxt = {SEED_ZERO[15:8], seed_low}; // RQ3 RQ13
			end else begin
				load_val_nxt = {seed_high, seed_low}; // RQ1 RQ2 RQ13
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			load_r     <= 1'b0;
			load_val_r <= SEED_ZERO;
		end else begin
			load_r     <= load_nxt;
			load_val_r <= load_val_nxt;
		end
	end

	// diagnostic pin; a selector write is forwarded so the pin follows
	// one edge after the write instead of two
	always_comb begin
		if (reg_wr && reg_addr == ADDR_DIAG_SEL) begin
			sel_eff = csr_diag_sel_t'(reg_wdata[SEL_W-1:0]); // RQ14
		end else begin
			sel_eff = csr_diag_sel_t'(diag_sel[SEL_W-1:0]);
		end
		unique case (sel_eff)
			SEL_LOW:     pin_nxt = 1'b0;             // RQ5
			SEL_HIGH:    pin_nxt = 1'b1;             // RQ5
			SEL_MILLER:  pin_nxt = miller_envelope;  // RQ6
			SEL_SERIAL:  pin_nxt = tx_serial_data;   // RQ6
			SEL_CARRIER: pin_nxt = carrier_demod;    // RQ7
			SEL_SUBCAR:  pin_nxt = subcarrier_demod; // RQ7
			// reserved codes park the pin low rather than float
			SEL_RSVD6:   pin_nxt = 1'b0;
			SEL_RSVD7:   pin_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pin_r <= 1'b0;
		end else begin
			pin_r <= pin_nxt;
		end
	end

	// FIFO water-level alerts
	assign fifo_free = FIFO_DEPTH - fifo_count;

	always_comb begin
		full_nxt  = fifo_free <= {1'b0, fill_threshold};  // RQ11
		empty_nxt = fifo_count <= {1'b0, fill_threshold}; // RQ12
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			full_r  <= 1'b0;
			empty_r <= 1'b0;
		end else begin
			full_r  <= full_nxt;
			empty_r <= empty_nxt;
		end
	end

	assign reg_rdata              = rdata_r;
	assign reg_rvalid             = rvalid_r;
	assign crc_load               = load_r;
	assign crc_load_value         = load_val_r;
	assign diag_output_pin        = pin_r;
	assign fifo_nearly_full_flag  = full_r;
	assign fifo_nearly_empty_flag = empty_r;

	// checks
	sequence seq_start_en;
		crc_start && crc_enable;
	endsequence

	sequence seq_write_sel_high;
		reg_wr && reg_addr == ADDR_DIAG_SEL &&
			reg_wdata[SEL_W-1:0] == SEL_HIGH;
	endsequence

	sequence seq_write_low_then_read;
		(reg_wr && reg_addr == ADDR_SEED_LOW) ##1
			(reg_rd && !reg_wr && reg_addr == ADDR_SEED_LOW);
	endsequence

	AST_LOAD_LOW: assert property (@(posedge clock) disable iff (rst) // RQ1
		seq_start_en |=> crc_load && crc_load_value[7:0] == $past(seed_low))
		else $error("low seed not loaded at start");

	AST_LOAD_HIGH: assert property (@(posedge clock) disable iff (rst) // RQ2
		seq_start_en and !crc_short_width_select
			|=> crc_load_value[15:8] == $past(seed_high))
		else $error("high seed not loaded in 16-bit mode");

	AST_SHORT_MODE: assert property (@(posedge clock) disable iff (rst) // RQ3
		seq_start_en and crc_short_width_select
			|=> crc_load_value[15:8] == SEED_ZERO[15:8])
		else $error("high seed used in 8-bit mode");

	AST_NO_LOAD: assert property (@(posedge clock) disable iff (rst) // RQ1
		!(crc_start && crc_enable) |=> !crc_load)
		else $error("preset without enabled start");

	AST_SEED_RESET: assert property (@(posedge clock) // RQ4
		rst |=> seed_low == RST_SEED && seed_high == RST_SEED &&
			rsvd_zero == RST_RSVD_ZERO)
		else $error("seed reset value wrong");

	AST_SEED_READBACK: assert property (@(posedge clock) disable iff (rst) // RQ4
		seq_write_low_then_read |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
		else $error("low seed read back wrong");

	AST_UNDEF_WO: assert property (@(posedge clock) disable iff (rst) // RQ10
		reg_rd && reg_addr == ADDR_RSVD_UNDEF |=> reg_rdata == READ_ZERO)
		else $error("write-only location readable");

	AST_PIN_CONST: assert property (@(posedge clock) disable iff (rst) // RQ5
		!reg_wr && diag_sel[SEL_W-1:0] == SEL_LOW ##1 1'b1 |-> !diag_output_pin)
		else $error("pin not low for code 000");

	AST_PIN_MILLER: assert property (@(posedge clock) disable iff (rst) // RQ6
		!reg_wr && diag_sel[SEL_W-1:0] == SEL_MILLER
			|=> diag_output_pin == $past(miller_envelope))
		else $error("pin not following envelope");

	AST_PIN_SUBCAR: assert property (@(posedge clock) disable iff (rst) // RQ7
		!reg_wr && diag_sel[SEL_W-1:0] == SEL_SUBCAR
			|=> diag_output_pin == $past(subcarrier_demod))
		else $error("pin not following subcarrier demod");

	AST_SEL_NEXT: assert property (@(posedge clock) disable iff (rst) // RQ14
		seq_write_sel_high |=> diag_output_pin)
		else $error("selector write not seen next cycle");

	AST_NEAR_FULL: assert property (@(posedge clock) disable iff (rst) // RQ11
		fifo_count <= FIFO_DEPTH
			|=> fifo_nearly_full_flag ==
				((FIFO_DEPTH - $past(fifo_count)) <= $past(fill_threshold)))
		else $error("nearly-full flag wrong");

	AST_NEAR_EMPTY: assert property (@(posedge clock) disable iff (rst) // RQ12
		1'b1 |=> fifo_nearly_empty_flag ==
			($past(fifo_count) <= {1'b0, $past(fill_threshold)}))
		else $error("nearly-empty flag wrong");

	sequence seq_write_sel_low;
		reg_wr && reg_addr == ADDR_DIAG_SEL &&
			reg_wdata[SEL_W-1:0] == SEL_LOW;
	endsequence

	AST_SEL_ZERO: assert property (@(posedge clock) disable iff (rst) // RQ14
		seq_write_sel_low |=> !diag_output_pin)
		else $error("selector write to low not seen next cycle");

	AST_PIN_HIGH: assert property (@(posedge clock) disable iff (rst) // RQ5
		!reg_wr && diag_sel[SEL_W-1:0] == SEL_HIGH |=> diag_output_pin)
		else $error("pin not high for code 001");

	AST_PIN_SERIAL: assert property (@(posedge clock) disable iff (rst) // RQ6
		!reg_wr && diag_sel[SEL_W-1:0] == SEL_SERIAL
			|=> diag_output_pin == $past(tx_serial_data))
		else $error("pin not following serial data");

	AST_PIN_CARRIER: assert property (@(posedge clock) disable iff (rst) // RQ7
		!reg_wr && diag_sel[SEL_W-1:0] == SEL_CARRIER
			|=> diag_output_pin == $past(carrier_demod))
		else $error("pin not following carrier demod");

	AST_RVALID: assert property (@(posedge clock) disable iff (rst) // RQ4
		1'b1 |=> reg_rvalid == $past(reg_rd))
		else $error("read valid not one cycle after strobe");
endmodule // csr_regs
`default_nettype wire

// file: verification/crc_seed_pin_mux_fifo_level_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module crc_seed_pin_mux_fifo_level_regs_tb;
	import csr_pkg::*;
	logic        clock, rst, reg_wr, reg_rd, reg_rvalid, crc_enable;
	logic        crc_short_width_select, tx_start, rx_start;
	logic        crc_calculate_command, crc_load, miller_envelope;
	logic        tx_serial_data, carrier_demod, subcarrier_demod;
	logic        diag_output_pin, fifo_nearly_full_flag;
	logic        fifo_nearly_empty_flag;
	logic [5:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [15:0] crc_load_value;
	logic [6:0]  fifo_count;
	int          failures, n_checks;

	csr_host host_u (.clock(clock), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	csr_regs dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.crc_enable(crc_enable),
		.crc_short_width_select(crc_short_width_select),
		.tx_start(tx_start), .rx_start(rx_start),
		.crc_calculate_command(crc_calculate_command),
		.crc_load(crc_load), .crc_load_value(crc_load_value),
		.miller_envelope(miller_envelope),
		.tx_serial_data(tx_serial_data), .carrier_demod(carrier_demod),
		.subcarrier_demod(subcarrier_demod),
		.diag_output_pin(diag_output_pin), .fifo_count(fifo_count),
		.fifo_nearly_full_flag(fifo_nearly_full_flag),
		.fifo_nearly_empty_flag(fifo_nearly_empty_flag));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic chk_val(string nm, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(string nm, logic e, logic g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic rd_chk(logic [5:0] a, logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		host_u.rd(a, d, ok);
		chk_bit("reg_rvalid", 1'b1, ok);
		chk_val("reg_rdata", {8'h00, e}, {8'h00, d});
	endtask
	task automatic wrrd_chk(logic [5:0] a, logic [7:0] v);
		logic [7:0] d;
		logic       ok;
		host_u.wr_rd(a, v, d, ok);
		chk_bit("reg_rvalid", 1'b1, ok);
		chk_val("reg_rdata", {8'h00, v}, {8'h00, d});
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic t_reset;
		rd_chk(ADDR_SEED_LOW, 8'h63);
		rd_chk(ADDR_SEED_HIGH, 8'h63);
		rd_chk(ADDR_RSVD_ZERO, 8'h00);
		rd_chk(ADDR_DIAG_SEL, 8'h00);
		rd_chk(ADDR_RSVD_UNDEF, READ_ZERO);
	endtask
	task automatic t_rw;
		wrrd_chk(ADDR_SEED_LOW, 8'hA5);
		host_u.wr(ADDR_SEED_HIGH, 8'h3C);
		host_u.wr(ADDR_RSVD_ZERO, 8'h00);
		rd_chk(ADDR_SEED_LOW, 8'hA5);
		rd_chk(ADDR_SEED_HIGH, 8'h3C);
		rd_chk(ADDR_RSVD_ZERO, 8'h00);
		rd_chk(6'h3F, 8'h00);
	endtask
	// k picks transmit, receive or calculate start
	task automatic start_chk(int k, logic en, logic [15:0] e);
		@(posedge clock);
		#1;
		crc_enable = en;
		tx_start = (k == 0);
		rx_start = (k == 1);
		crc_calculate_command = (k == 2);
		@(posedge clock);
		#1;
		{tx_start, rx_start, crc_calculate_command} = 3'b000;
		chk_bit("crc_load", en, crc_load);
		chk_val("crc_load_value", e, crc_load_value);
		@(posedge clock);
		#1;
		chk_bit("crc_load", 1'b0, crc_load);
	endtask
	task automatic t_crc;
		for (int k = 0; k < 3; k++) start_chk(k, 1'b1, 16'h3CA5);
		crc_short_width_select = 1'b1;
		for (int k = 0; k < 3; k++) start_chk(k, 1'b1, 16'h00A5);
		start_chk(1, 1'b0, 16'h00A5);
		crc_short_width_select = 1'b0;
	endtask
	// chosen patterns flip the selected source between the two checks of each code 2 to 5
	task automatic t_diag;
		logic [3:0] src;
		for (int c = 0; c < 6; c++) begin
			for (int p = 0; p < 2; p++) begin
				src = p ? 4'hA : 4'h5;
				{miller_envelope, tx_serial_data, carrier_demod,
					subcarrier_demod} = src;
				if (p == 0) begin
					host_u.wr(ADDR_DIAG_SEL, {5'h00, c[2:0]});
				end else begin
					@(posedge clock);
					#1;
				end
				chk_bit("diag_output_pin", (c < 2) ? c[0] : src[5 - c],
					diag_output_pin);
			end
		end
	endtask
	task automatic t_fifo(logic [5:0] thr);
		logic [6:0] cs [6];
		cs = '{{1'b0, thr}, {1'b0, thr} + 7'h01, 7'h3F - thr,
			7'h40 - thr, 7'h00, 7'h40};
		host_u.wr(ADDR_FIFO_THR, {2'b00, thr});
		for (int i = 0; i < 6; i++) begin
			fifo_count = cs[i];
			@(posedge clock);
			#1;
			chk_bit("nearly_full", (7'h40 - cs[i]) <= {1'b0, thr},
				fifo_nearly_full_flag);
			chk_bit("nearly_empty", cs[i] <= {1'b0, thr},
				fifo_nearly_empty_flag);
		end
	endtask
	// reset in mid-run must bring back the pin, crc_load and every readable register's reset value
	task automatic t_rst_mid;
		host_u.wr(ADDR_DIAG_SEL, 8'h01);
		chk_bit("diag_output_pin", 1'b1, diag_output_pin);
		rst = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		chk_bit("diag_output_pin", 1'b0, diag_output_pin);
		chk_bit("crc_load", 1'b0, crc_load);
		t_reset();
		rd_chk(ADDR_FIFO_THR, 8'h08);
	endtask

	initial begin
		#400000;
		failures++;
		final_report();
	end
	initial begin
		failures = 0;
		n_checks = 0;
		rst = 1'b1;
		{crc_enable, crc_short_width_select, tx_start, rx_start} = 4'h0;
		crc_calculate_command = 1'b0;
		{miller_envelope, tx_serial_data} = 2'b00;
		{carrier_demod, subcarrier_demod} = 2'b00;
		fifo_count = 7'h00;
		repeat (8) @(posedge clock);
		#1;
		rst = 1'b0;
		t_reset();
		rd_chk(ADDR_FIFO_THR, 8'h08);
		t_rw();
		t_crc();
		t_diag();
		t_fifo(6'h08);
		t_fifo(6'h05);
		t_fifo(6'h00);
		t_rst_mid();
		final_report();
	end
endmodule // crc_seed_pin_mux_fifo_level_regs_tb
`default_nettype wire

// file: verification/csr_host.sv
`timescale 1ns/1ns
`default_nettype none
module csr_host (
	input  wire logic       clock,     // core clock
	output logic      [5:0] reg_addr,  // register address
	output logic      [7:0] reg_wdata, // write data
	output logic            reg_wr,    // write strobe
	output logic            reg_rd,    // read strobe
	input  wire logic [7:0] reg_rdata, // read data
	input  wire logic       reg_rvalid // read data valid
);
	initial begin
		reg_addr = 6'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// idle bus shows inverted leftovers so stale values never match
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clock);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// answer is due one cycle after the strobe
	task automatic rd(input logic [5:0] a, output logic [7:0] d,
			output logic ok);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clock);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		ok = reg_rvalid;
		d = reg_rdata;
	endtask
	// write, then read the same address on the very next edge
	task automatic wr_rd(input logic [5:0] a, input logic [7:0] d,
			output logic [7:0] q, output logic ok);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clock);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(posedge clock);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
		ok = reg_rvalid;
		q = reg_rdata;
	endtask
endmodule // csr_host
`default_nettype wire
